//--- rtl/window_ctrl_pkg.sv
// Purpose : Constants for the card window enable and I/O window control bank
// Assumes : Byte-wide registers, memory offsets and compatibility indexes
// Notes   : Socket B index sits at socket A index plus 8'h40
`default_nettype none
package window_ctrl_pkg;
  // Memory-space offsets from the socket base
  localparam logic [11:0] OFS_WIN_ENABLE  = 12'h806;
  localparam logic [11:0] OFS_IO_CTRL     = 12'h807;
  // Compatibility indexes, socket A and socket B
  localparam logic [7:0]  IDX_WIN_ENABLE_A = 8'h06;
  localparam logic [7:0]  IDX_WIN_ENABLE_B = 8'h46;
  localparam logic [7:0]  IDX_IO_CTRL_A    = 8'h07;
  localparam logic [7:0]  IDX_IO_CTRL_B    = 8'h47;
  // Window enable fields
  localparam int          BIT_IO_WIN1_ON   = 7;
  localparam int          BIT_IO_WIN0_ON   = 6;
  localparam int          BIT_WIN_RSVD     = 5;
  localparam int          NUM_MEM_WIN      = 5;
  localparam logic [7:0]  WIN_ENABLE_MASK  = 8'hDF;
  // I/O control fields, window 1 nibble is 7:4, window 0 nibble is 3:0
  localparam int          IO_NIB_W         = 4;
  localparam int          NIB_EXTRA_WAIT   = 3;
  localparam int          NIB_SHORT_CYCLE  = 2;
  localparam int          NIB_AUTO_SIZE    = 1;
  localparam int          NIB_WIDTH_SEL    = 0;
  // Reset values
  localparam logic [7:0]  RST_WIN_ENABLE   = 8'h00;
  localparam logic [7:0]  RST_IO_CTRL      = 8'h00;
  // Card-side cycle lengths in card clock units
  localparam logic [3:0]  ISA_STD_8BIT     = 4'h6;
  localparam logic [3:0]  ISA_SHORT_8BIT   = 4'h3;
  localparam logic [3:0]  ISA_STD_16BIT    = 4'h3;
  localparam logic [3:0]  ISA_WAIT_EXTRA   = 4'h1;
  // Card-side clock divider, in system clocks per card clock
  localparam int          ISA_CLK_DIV      = 12;
endpackage : window_ctrl_pkg
`default_nettype wire

//--- rtl/pccard_window_enable_io_ctrl.sv
// Purpose : Window gating and I/O window timing/width control for one socket
// Assumes : Host decode presents one-cycle requests; card cycle is one at a time
// Notes   : Window address ranges arrive as inputs from their own registers
`timescale 1ns/1ps
`default_nettype none
module pccard_window_enable_io_ctrl #(
  parameter int ADDR_W = 24,              // Host cycle address width
  parameter int IO_W   = 16,              // I/O window address width
  parameter int NUM_WIN = window_ctrl_pkg::NUM_MEM_WIN, // Memory windows
  parameter bit SOCKET_B = 1'b0           // Selects socket B index pair
) (
  input  wire logic                clk_sys,        // System clock
  input  wire logic                srst,           // Sync reset, active high
  // Register access, memory space
  input  wire logic                mem_reg_sel,    // Memory register cycle
  input  wire logic                mem_reg_write,  // 1 write, 0 read
  input  wire logic [11:0]         mem_reg_offset, // Offset from socket base
  // Register access, compatibility index/data
  input  wire logic                idx_reg_sel,    // Indexed register cycle
  input  wire logic                idx_reg_write,  // 1 write, 0 read
  input  wire logic [7:0]          idx_reg_index,  // Compatibility index
  input  wire logic [7:0]          reg_wdata,      // Write data
  output logic      [7:0]          reg_rdata,      // Read data
  output logic                     reg_rvalid,     // Read data strobe
  // Window ranges from the address registers
  input  wire logic [NUM_WIN-1:0][ADDR_W-1:0] mem_win_start, // Mem starts
  input  wire logic [NUM_WIN-1:0][ADDR_W-1:0] mem_win_end,   // Mem ends
  input  wire logic [1:0][IO_W-1:0]  io_win_start,  // I/O starts
  input  wire logic [1:0][IO_W-1:0]  io_win_end,    // I/O ends
  // Host cycle request
  input  wire logic                host_req,       // One-cycle request
  input  wire logic                host_is_io,     // 1 I/O, 0 memory
  input  wire logic [ADDR_W-1:0]   host_addr,      // Cycle address
  // Card side
  input  wire logic                card_wide_io_indication, // Card 16-bit I/O
  output logic                     host_claim,     // Cycle claimed, pulse
  output logic [NUM_WIN-1:0]       mem_win_hit,    // Claimed memory window
  output logic [1:0]               io_win_hit,     // Claimed I/O window
  output logic                     card_io_16bit,  // Width of I/O cycle
  output logic                     card_busy,      // Card I/O cycle running
  output logic                     card_done       // Card I/O cycle end pulse
);
  // Refuse parameter values the decode cannot serve, at elaboration
  // I/O addresses are a low slice of the host address
  if (IO_W > ADDR_W || IO_W < 1) begin : g_bad_io_w
    $error("IO_W must lie between 1 and ADDR_W");
  end
  // Only five enable bits exist for memory windows
  if (NUM_WIN < 1 || NUM_WIN > window_ctrl_pkg::NUM_MEM_WIN) begin : g_bad_win
    $error("NUM_WIN must lie between 1 and the memory enable bits");
  end

  // Compatibility indexes for this socket
  // Socket B's pair sits one block above socket A's; the memory offsets
  // need no such choice because each socket has its own base
  // Chosen at elaboration, so one build serves one socket
  localparam logic [7:0] IDX_EN = SOCKET_B ?
    window_ctrl_pkg::IDX_WIN_ENABLE_B : window_ctrl_pkg::IDX_WIN_ENABLE_A;
  localparam logic [7:0] IDX_IO = SOCKET_B ?
    window_ctrl_pkg::IDX_IO_CTRL_B : window_ctrl_pkg::IDX_IO_CTRL_A;

  // Card I/O cycle states, one-hot so a glitch to an illegal code is seen
  // by the default branch and folded back to idle
  // Idle is the only state in which a host request is taken
  // End lasts one cycle so done and the fall of busy line up
  typedef enum logic [2:0] {
    CYC_IDLE = 3'b001,                    // No card I/O cycle
    CYC_RUN  = 3'b010,                    // Counting card clocks
    CYC_END  = 3'b100                     // Reporting completion
  } cyc_state_t;

  // Stored state, then the combinational decode of the current request
  logic [7:0]        card_window_enable;          // Window enable register
  logic [7:0]        io_window_timing_width_ctrl; // I/O control register
  logic              hit_en;              // Access targets enable register
  logic              hit_io;              // Access targets control register
  logic              acc_wr;              // Write strobe of the access
  logic              acc_rd;              // Read strobe of the access
  logic [NUM_WIN-1:0] mem_range;          // Address inside memory window
  logic [1:0]        io_range;            // Address inside I/O window
  logic [NUM_WIN-1:0] mem_go;             // Enabled and in range
  logic [1:0]        io_go;               // Enabled and in range
  logic [1:0]        io_on;               // I/O window enable bits
  logic [1:0]        win_wide;            // Resolved width per window
  logic [3:0]        next_len;            // Card clocks for the new cycle
  logic [3:0]        len_left;            // Card clocks remaining
  logic [$clog2(window_ctrl_pkg::ISA_CLK_DIV)-1:0] div_cnt; // Card divider
  logic              card_tick;           // One-cycle card clock enable
  cyc_state_t        cyc_state;           // Card cycle state
  logic              io_sel;              // Chosen I/O window, 1 = window 1

  // Decode both access paths onto the two registers
  // Memory space uses the fixed offsets from the socket base
  // The index path uses this socket's pair of compatibility indexes
  // Both paths land on the same flip-flops, so a write through one is
  // read back through the other
  // The host must not raise both selects at once; if it does, a write
  // through either one still lands, and the read returns whichever hits
  always_comb begin
    hit_en = (mem_reg_sel && mem_reg_offset == window_ctrl_pkg::OFS_WIN_ENABLE)
          || (idx_reg_sel && idx_reg_index == IDX_EN);
    hit_io = (mem_reg_sel && mem_reg_offset == window_ctrl_pkg::OFS_IO_CTRL)
          || (idx_reg_sel && idx_reg_index == IDX_IO);
    acc_wr = (mem_reg_sel && mem_reg_write) || (idx_reg_sel && idx_reg_write);
    acc_rd = (mem_reg_sel && !mem_reg_write) || (idx_reg_sel && !idx_reg_write);
  end

  // Window enable register; reserved bit is masked off on write
  // Masking at the write keeps the stored bit zero, so no window logic
  // can ever see a stale reserved bit
  // Reset clears every enable, so nothing is claimed until software
  // has programmed a range and set its bit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      card_window_enable <= window_ctrl_pkg::RST_WIN_ENABLE;
    end else if (hit_en && acc_wr) begin
      card_window_enable <= reg_wdata & window_ctrl_pkg::WIN_ENABLE_MASK;
    end
  end

  // I/O window timing and width register
  // Upper nibble serves window 1 and lower nibble window 0
  // All eight bits are plain storage; their meaning is applied only
  // when a card cycle starts, so a change mid-cycle waits for the next
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      io_window_timing_width_ctrl <= window_ctrl_pkg::RST_IO_CTRL;
    end else if (hit_io && acc_wr) begin
      io_window_timing_width_ctrl <= reg_wdata;
    end
  end

  // Read path, registered; unmapped reads return zero
  // Read data stands for one cycle beside the strobe and is zero at all
  // other times, so a shared host read bus may simply OR the sockets
  // The reserved bit is masked again here as a second guard
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= acc_rd;
      if (acc_rd && hit_en) begin
        reg_rdata <= card_window_enable & window_ctrl_pkg::WIN_ENABLE_MASK;
      end else if (acc_rd && hit_io) begin
        reg_rdata <= io_window_timing_width_ctrl;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // I/O window enables, pulled out so the match loop can index them
  assign io_on[1] = card_window_enable[window_ctrl_pkg::BIT_IO_WIN1_ON];
  assign io_on[0] = card_window_enable[window_ctrl_pkg::BIT_IO_WIN0_ON];

  // Memory window match, one per window
  // Ranges are inclusive at both ends
  // Several memory windows may match at once; all of them are reported
  // in the hit vector and software is expected to avoid overlaps
  // Memory requests never start the card I/O sequencer
  for (genvar w = 0; w < NUM_WIN; w++) begin : g_mem
    assign mem_range[w] = host_addr >= mem_win_start[w]
                       && host_addr <= mem_win_end[w];
    // Address match alone never claims; enable bit gates it
    assign mem_go[w] = !host_is_io && mem_range[w]
                    && card_window_enable[w];
  end

  // I/O window match and per-window width resolution
  // Only the low address bits take part, as I/O space is narrower
  // Auto-size reads the card indication in the request cycle; a card
  // that changes it later in the cycle is not followed
  for (genvar w = 0; w < 2; w++) begin : g_io
    localparam int B = w * window_ctrl_pkg::IO_NIB_W;
    assign io_range[w] = host_addr[IO_W-1:0] >= io_win_start[w]
                      && host_addr[IO_W-1:0] <= io_win_end[w];
    assign io_go[w] = host_is_io && io_range[w] && io_on[w];
    // Auto-size overrides the size bit
    assign win_wide[w] =
      io_window_timing_width_ctrl[B + window_ctrl_pkg::NIB_AUTO_SIZE]
        ? card_wide_io_indication
        : io_window_timing_width_ctrl[B + window_ctrl_pkg::NIB_WIDTH_SEL];
  end

  // Window 0 wins when both I/O windows overlap
  // With neither window matching this still points at window 1, but
  // nothing uses it then because no I/O cycle starts
  assign io_sel = !io_go[0];

  // Length of the card I/O cycle in card clocks
  // The wait bit only matters for wide cycles and the zero-wait bit only
  // for narrow ones, so each is looked at inside its own width branch
  // Bit positions come from the chosen window's nibble base
  always_comb begin
    next_len = window_ctrl_pkg::ISA_STD_8BIT;
    if (win_wide[io_sel]) begin
      next_len = window_ctrl_pkg::ISA_STD_16BIT;
      if (io_window_timing_width_ctrl[{io_sel, 2'b00}
            + 3'(window_ctrl_pkg::NIB_EXTRA_WAIT)]) begin
        next_len = window_ctrl_pkg::ISA_STD_16BIT
                 + window_ctrl_pkg::ISA_WAIT_EXTRA;
      end
    end else if (io_window_timing_width_ctrl[{io_sel, 2'b00}
                   + 3'(window_ctrl_pkg::NIB_SHORT_CYCLE)]) begin
      next_len = window_ctrl_pkg::ISA_SHORT_8BIT;
    end
  end

  // Divider giving the card clock enable; restarts with each cycle
  // Held in reset outside the run state, so every cycle sees a full
  // first card clock rather than a partial one left from the last
  // Costs about one system clock of latency per cycle, which is well
  // inside the slack of a card clock
  always_ff @(posedge clk_sys) begin
    if (srst || cyc_state != CYC_RUN) begin
      div_cnt   <= '0;
      card_tick <= 1'b0;
    end else if (div_cnt == ($bits(div_cnt))'(window_ctrl_pkg::ISA_CLK_DIV - 1)) begin
      div_cnt   <= '0;
      card_tick <= 1'b1;
    end else begin
      div_cnt   <= div_cnt + 1'b1;
      card_tick <= 1'b0;
    end
  end

  // Claim outputs, one-cycle pulse per accepted request
  // All claim outputs are registered, so the host sees them one cycle
  // after the request
  // A disabled window never reaches the go vectors, whatever its range
  // holds, so it can never be claimed
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      host_claim  <= 1'b0;
      mem_win_hit <= '0;
      io_win_hit  <= '0;
    end else begin
      // Requests during a running I/O cycle are not claimed
      host_claim  <= host_req && cyc_state == CYC_IDLE
                  && (|mem_go || |io_go);
      mem_win_hit <= (host_req && cyc_state == CYC_IDLE) ? mem_go : '0;
      io_win_hit  <= (host_req && cyc_state == CYC_IDLE && |io_go)
                   ? (io_sel ? 2'b10 : 2'b01) : 2'b00;
    end
  end

  // Card I/O cycle sequencer
  // Idle: take an I/O request that hit an enabled window, latch the
  // length and width, raise busy
  // Run: count card clocks down to the last one
  // End: drop busy and pulse done in the same cycle
  // Only one card cycle runs at a time; I/O and memory requests that
  // arrive meanwhile are not claimed and must be retried by the host
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cyc_state     <= CYC_IDLE;
      len_left      <= 4'h0;
      card_io_16bit <= 1'b0;
      card_busy     <= 1'b0;
      card_done     <= 1'b0;
    end else begin
      card_done <= 1'b0;
      case (cyc_state)
        CYC_IDLE: begin
          if (host_req && |io_go) begin
            cyc_state     <= CYC_RUN;
            len_left      <= next_len;
            card_io_16bit <= win_wide[io_sel];
            card_busy     <= 1'b1;
          end
        end
        CYC_RUN: begin
          if (card_tick) begin
            if (len_left == 4'h1) begin
              cyc_state <= CYC_END;
            end
            len_left <= len_left - 4'h1;
          end
        end
        CYC_END: begin
          cyc_state <= CYC_IDLE;
          card_busy <= 1'b0;
          card_done <= 1'b1;
        end
        default: begin
          cyc_state <= CYC_IDLE;
          card_busy <= 1'b0;
        end
      endcase
    end
  end
endmodule // pccard_window_enable_io_ctrl
`default_nettype wire

//--- sim/pccard_window_properties.sv
// Purpose : Port-level checks for the window enable and I/O control bank
// Assumes : Sees only the top module ports, one clock domain
// Notes   : Card cycle span is bounded by the longest cycle plus its start and end cycles
`timescale 1ns/1ps
`default_nettype none
module pccard_window_properties (
  input wire logic        clk_sys,        // System clock
  input wire logic        srst,           // Sync reset
  input wire logic        mem_reg_sel,    // Memory register cycle
  input wire logic        mem_reg_write,  // Memory cycle is a write
  input wire logic [11:0] mem_reg_offset, // Offset from socket base
  input wire logic        idx_reg_sel,    // Indexed register cycle
  input wire logic        idx_reg_write,  // Indexed cycle is a write
  input wire logic [7:0]  reg_rdata,      // Read data
  input wire logic        reg_rvalid,     // Read strobe
  input wire logic        host_req,       // Host request
  input wire logic        host_claim,     // Claim pulse
  input wire logic [4:0]  mem_win_hit,    // Memory hits
  input wire logic [1:0]  io_win_hit,     // I/O hits
  input wire logic        card_busy,      // Card cycle running
  input wire logic        card_done       // Card cycle end
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic       rd;       // A read access this cycle
  logic [7:0] busy_cnt; // Cycles the card cycle has run so far
  assign rd = (mem_reg_sel && !mem_reg_write) ||
              (idx_reg_sel && !idx_reg_write);
  // Count busy cycles; held at zero when idle so the bound is per cycle
  always_ff @(posedge clk_sys) begin
    if (srst || !card_busy) begin
      busy_cnt <= 8'h00;
    end else begin
      busy_cnt <= busy_cnt + 8'h01;
    end
  end
  a_read_answer: assert property (rd |=> reg_rvalid)
    else $error("read got no strobe");
  a_strobe_cause: assert property (reg_rvalid |-> $past(rd))
    else $error("strobe without read");
  a_rsvd_zero: assert property (reg_rvalid && $past(mem_reg_sel &&
    !mem_reg_write && mem_reg_offset == window_ctrl_pkg::OFS_WIN_ENABLE)
    |-> !reg_rdata[5]) else $error("reserved bit read as one");
  a_claim_cause: assert property (host_claim |-> $past(host_req))
    else $error("claim without request");
  a_hit_claimed: assert property ((|mem_win_hit || |io_win_hit)
    |-> host_claim) else $error("window hit without claim");
  a_io_onehot: assert property ($onehot0(io_win_hit))
    else $error("two I/O windows claimed");
  a_io_busy: assert property (host_claim && |io_win_hit
    |-> card_busy ##1 card_busy) else $error("I/O claim did not start card");
  a_done_ends: assert property (card_done |-> !card_busy &&
    $past(card_busy)) else $error("done without ending busy");
  // Longest cycle: six card clocks of twelve, plus two for start and end
  a_busy_bound: assert property (busy_cnt <= 8'h4A)
    else $error("card cycle too long");
  // Shortest cycle: three card clocks of twelve, plus the same two
  a_len_floor: assert property (card_done |-> busy_cnt >= 8'h26)
    else $error("card cycle too short");
  a_reset_quiet: assert property (disable iff (1'b0) srst
    |=> !host_claim && !card_busy) else $error("activity after reset");
  cover property (host_claim && |io_win_hit);
  cover property (host_claim && |mem_win_hit);
  cover property (card_done);
endmodule // pccard_window_properties
`default_nettype wire

//--- sim/card_io_model.sv
// Purpose : Card side model driving the 16-bit I/O indication
// Assumes : Bench chooses how the card decodes each cycle
// Notes   : Moves just after the rising edge, as a card decode would
`timescale 1ns/1ps
`default_nettype none
module card_io_model (
  input  wire logic clk_sys,                 // System clock
  input  wire logic wide_cfg,                // Card decodes as 16-bit
  output logic      card_wide_io_indication  // Width level to the block
);
  // Level follows the decode one edge later
  always_ff @(posedge clk_sys) begin
    card_wide_io_indication <= wide_cfg;
  end
endmodule // card_io_model
`default_nettype wire

//--- sim/pccard_window_enable_io_ctrl_tb.sv
// Purpose : Self-checking bench for the window enable and I/O control bank
// Assumes : Socket A and socket B indexes; card model gives the width indication
// Notes   : Card cycle length judged in card clocks, rounding overhead off
`timescale 1ns/1ps
`default_nettype none
module pccard_window_enable_io_ctrl_tb;
  logic             clk_sys, srst, mem_reg_sel, mem_reg_write, idx_reg_sel;
  logic             idx_reg_write, reg_rvalid, host_req, host_is_io;
  logic             host_claim, wide_cfg, wide_ind, io16, card_busy;
  logic             card_done;       // Card cycle end pulse
  logic [11:0]      mem_reg_offset;  // Memory-space offset
  logic [7:0]       idx_reg_index, reg_wdata, reg_rdata, q;
  logic [7:0]       reg_rdata_b, q_b;  // Socket B read data and capture
  logic [23:0]      host_addr;       // Host cycle address
  logic [4:0][23:0] m_start, m_end;  // Memory window ranges
  logic [1:0][15:0] i_start, i_end;  // I/O window ranges
  logic [4:0]       mem_win_hit;     // Memory hits
  logic [1:0]       io_win_hit;      // I/O hits
  int               mismatches = 0, n_checks = 0, cyc;
  // Ctrl byte, indication, 16-bit, spare, length in card clocks
  logic [15:0] tc [10] = '{16'h0006, 16'h0403, 16'h0143, 16'h0944,
    16'h0806, 16'h0543, 16'h02C3, 16'h0306, 16'h9044, 16'h4003};
  pccard_window_enable_io_ctrl pccard_window_enable_io_ctrl_i (
    .clk_sys(clk_sys), .srst(srst), .mem_reg_sel(mem_reg_sel),
    .mem_reg_write(mem_reg_write), .mem_reg_offset(mem_reg_offset),
    .idx_reg_sel(idx_reg_sel), .idx_reg_write(idx_reg_write),
    .idx_reg_index(idx_reg_index), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .mem_win_start(m_start),
    .mem_win_end(m_end), .io_win_start(i_start), .io_win_end(i_end),
    .host_req(host_req), .host_is_io(host_is_io), .host_addr(host_addr),
    .card_wide_io_indication(wide_ind), .host_claim(host_claim),
    .mem_win_hit(mem_win_hit), .io_win_hit(io_win_hit),
    .card_io_16bit(io16), .card_busy(card_busy), .card_done(card_done));
  card_io_model card_io_model_i (.clk_sys(clk_sys), .wide_cfg(wide_cfg),
    .card_wide_io_indication(wide_ind));
  // Socket B build on the same wires, told apart only by its indexes
  pccard_window_enable_io_ctrl #(.SOCKET_B(1'b1))
    pccard_window_enable_io_ctrl_b_i (
    .clk_sys(clk_sys), .srst(srst), .mem_reg_sel(mem_reg_sel),
    .mem_reg_write(mem_reg_write), .mem_reg_offset(mem_reg_offset),
    .idx_reg_sel(idx_reg_sel), .idx_reg_write(idx_reg_write),
    .idx_reg_index(idx_reg_index), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata_b), .reg_rvalid(), .mem_win_start(m_start),
    .mem_win_end(m_end), .io_win_start(i_start), .io_win_end(i_end),
    .host_req(host_req), .host_is_io(host_is_io), .host_addr(host_addr),
    .card_wide_io_indication(wide_ind), .host_claim(),
    .mem_win_hit(), .io_win_hit(), .card_io_16bit(), .card_busy(),
    .card_done());
  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One register cycle; m picks memory space, else the index path
  task automatic rw(input bit m, w, input logic [11:0] a, logic [7:0] d);
    @(negedge clk_sys);
    mem_reg_sel = m;
    idx_reg_sel = !m;
    mem_reg_write = w;
    idx_reg_write = w;
    mem_reg_offset = a;
    idx_reg_index = a[7:0];
    reg_wdata = d;
    @(negedge clk_sys);
    q = reg_rdata;
    q_b = reg_rdata_b;
    if (!w) chk("rvalid", 16'(reg_rvalid), 16'h0001);
    mem_reg_sel = 1'b0;
    idx_reg_sel = 1'b0;
  endtask
  // One-cycle host request; claim outputs are settled on return
  task automatic hreq(input bit io, input logic [23:0] a);
    @(negedge clk_sys);
    host_req = 1'b1;
    host_is_io = io;
    host_addr = a;
    @(negedge clk_sys);
    host_req = 1'b0;
  endtask
  // Reset, then both registers must read back cleared
  task automatic t_reset;
    srst = 1'b1;
    repeat (8) @(negedge clk_sys);
    srst = 1'b0;
    rw(1, 0, 12'h806, 8'h00);
    chk("enable_rst", 16'(q), 16'h0000);
    rw(0, 0, 12'h007, 8'h00);
    chk("ioctrl_rst", 16'(q), 16'h0000);
    $display("reset test done");
  endtask
  // Cross-path access, reserved bit and an unmapped place
  task automatic t_regs;
    rw(1, 1, 12'h806, 8'hFF);
    rw(0, 0, 12'h006, 8'h00);
    chk("enable_rd", 16'(q), 16'h00DF);
    rw(0, 1, 12'h007, 8'hA5);
    rw(1, 0, 12'h807, 8'h00);
    chk("ioctrl_rd", 16'(q), 16'h00A5);
    rw(1, 1, 12'h808, 8'h33);
    rw(1, 0, 12'h808, 8'h00);
    chk("unmapped", 16'(q), 16'h0000);
    rw(0, 1, 12'h046, 8'h35);
    rw(0, 0, 12'h046, 8'h00);
    chk("sockb_en", 16'(q_b), 16'h0015);
    chk("socka_46", 16'(q), 16'h0000);
    rw(0, 1, 12'h047, 8'h5A);
    rw(0, 0, 12'h006, 8'h00);
    chk("socka_en", 16'(q), 16'h00DF);
    chk("sockb_06", 16'(q_b), 16'h0000);
    rw(0, 0, 12'h047, 8'h00);
    chk("sockb_io", 16'(q_b), 16'h005A);
    chk("socka_47", 16'(q), 16'h0000);
    $display("register test done");
  endtask
  // Each memory window alone: hit inside, none outside, none disabled
  task automatic t_mem;
    for (int i = 0; i < 5; i++) begin
      rw(1, 1, 12'h806, 8'h01 << i);
      hreq(0, m_start[i] + 24'h000010);
      chk("mem_hit", 16'(mem_win_hit), 16'(5'h01 << i));
      hreq(0, m_end[i] + 24'h000001);
      chk("outside", 16'(host_claim), 16'h0000);
      rw(1, 1, 12'h806, 8'h00);
      hreq(0, m_start[i]);
      chk("mem_off", 16'(host_claim), 16'h0000);
    end
    hreq(1, 24'h000150);
    chk("io_off", 16'(host_claim), 16'h0000);
    $display("memory window test done");
  endtask
  // Every timing and width setting on I/O window 0, wait and short settings on window 1
  task automatic t_io;
    rw(1, 1, 12'h806, 8'hC0);
    for (int k = 0; k < 10; k++) begin
      rw(1, 1, 12'h807, tc[k][15:8]);
      wide_cfg = tc[k][7];
      hreq(1, (tc[k][15:12] != 4'h0) ? 24'h000350 : 24'h000150);
      chk("io_hit", 16'(io_win_hit),
        (tc[k][15:12] != 4'h0) ? 16'h0002 : 16'h0001);
      chk("width", 16'(io16), 16'(tc[k][6]));
      chk("busy", 16'(card_busy), 16'h0001);
      hreq(1, 24'h000150);
      chk("busy_refuse", 16'(host_claim), 16'h0000);
      cyc = 2;
      while (card_done !== 1'b1 && cyc < 200) begin
        @(negedge clk_sys);
        cyc++;
      end
      chk("length", 16'((cyc + 6) / 12), 16'(tc[k][3:0]));
      chk("idle", 16'(card_busy), 16'h0000);
    end
    $display("I/O window test done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence; ranges leave gaps so an end plus one misses
  initial begin
    {mem_reg_sel, mem_reg_write, idx_reg_sel, idx_reg_write} = 4'h0;
    {host_req, host_is_io, wide_cfg, srst} = 4'h1;
    {mem_reg_offset, idx_reg_index, reg_wdata, host_addr} = '0;
    for (int i = 0; i < 5; i++) begin
      m_start[i] = 24'(i) << 16;
      m_end[i] = (24'(i) << 16) + 24'h000FFF;
    end
    i_start = {16'h0300, 16'h0100};
    i_end = {16'h03FF, 16'h01FF};
    t_reset();
    t_regs();
    t_mem();
    t_io();
    t_reset();
    end_sim();
  end
  // Watchdog, well past the expected run of under a thousand cycles
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule // pccard_window_enable_io_ctrl_tb
bind pccard_window_enable_io_ctrl pccard_window_properties
  pccard_window_properties_i (.clk_sys(clk_sys), .srst(srst),
  .mem_reg_sel(mem_reg_sel), .mem_reg_write(mem_reg_write),
  .mem_reg_offset(mem_reg_offset), .idx_reg_sel(idx_reg_sel),
  .idx_reg_write(idx_reg_write), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .host_req(host_req), .host_claim(host_claim),
  .mem_win_hit(mem_win_hit), .io_win_hit(io_win_hit),
  .card_busy(card_busy), .card_done(card_done));
`default_nettype wire
